// ===== hw/tpsr_defs.svh
// Purpose: constants of the tof pixel spi readout
// Assumes: included by the package and the readout
// Notes: command layout, register map, marker codes
`ifndef TPSR_DEFS_SVH
`define TPSR_DEFS_SVH
`define TPSR_CMD_W          16
`define TPSR_CMD_NOP        16'h0000
`define TPSR_CMD_BUSY       16'hffff
`define TPSR_CMD_PSEL_BIT   15
`define TPSR_CMD_WR_BIT     14
`define TPSR_ADDR_MSB       13
`define TPSR_ADDR_LSB       8
`define TPSR_PAGE_MSB       11
`define TPSR_PAGE_LSB       8
`define TPSR_DATA_MSB       7
`define TPSR_PAGE_PIX       4'h2
`define TPSR_PAGE_MODE      4'h4
`define TPSR_REG_PIX_DATA   6'h0c
`define TPSR_REG_SAT_COL    6'h0d
`define TPSR_REG_SAT_ROW    6'h0e
`define TPSR_REG_OVF_COL    6'h10
`define TPSR_REG_OVF_ROW    6'h11
`define TPSR_REG_UNF_COL    6'h12
`define TPSR_REG_UNF_ROW    6'h13
`define TPSR_REG_RD_MODE    6'h15
`define TPSR_MODE_RESET     8'h00
`define TPSR_EMBED_OFF_BIT  6
`define TPSR_CODE_SAT       12'h7ff
`define TPSR_CODE_OVF       12'h7fe
`define TPSR_CODE_UNF       12'h800
`define TPSR_CODE_MAX       12'h7fd
`define TPSR_CODE_MIN       12'h801
`define TPSR_FLAG_SAT       0
`define TPSR_FLAG_OVF       1
`define TPSR_FLAG_UNF       2
`define TPSR_LAST_PAIR      5'h1f
`define TPSR_LAST_BIT       4'hf
`define TPSR_LAST_BYTE      2'h2
`define TPSR_BOOT_TIME_US   1000
`define TPSR_CLK_MHZ        25
`define TPSR_FIFO_DEPTH     4
`endif

// ===== hw/tpsr_pkg.sv
// Purpose: types and helpers of the tof pixel spi readout
// Assumes: defs header on the include path
// Notes: none
`include "tpsr_defs.svh"
package tpsr_pkg;
    typedef logic [2:0] tpsr_flags_t;
    typedef enum logic [2:0] {
        FETCH_IDLE = 3'b000,
        FETCH_REQ  = 3'b001,
        FETCH_PUSH = 3'b010
    } tpsr_fetch_e;

    // centre-out row order for row read 0..7
    function automatic logic [2:0] tpsr_row_of(input logic [2:0] idx);
        logic [2:0] r;
        r = 3'h0;
        unique case (idx)
            3'h0: r = 3'h3;
            3'h1: r = 3'h4;
            3'h2: r = 3'h2;
            3'h3: r = 3'h5;
            3'h4: r = 3'h1;
            3'h5: r = 3'h6;
            3'h6: r = 3'h0;
            3'h7: r = 3'h7;
        endcase
        return r;
    endfunction : tpsr_row_of

    function automatic logic [11:0] tpsr_encode(input logic [11:0] v, input tpsr_flags_t f,
                                                input logic embed_off);
        logic [11:0] r;
        r = v;
        if (!embed_off) begin
            if (f[`TPSR_FLAG_SAT]) r = `TPSR_CODE_SAT;
            else if (f[`TPSR_FLAG_OVF]) r = `TPSR_CODE_OVF;
            else if (f[`TPSR_FLAG_UNF]) r = `TPSR_CODE_UNF;
            else if (v == `TPSR_CODE_SAT || v == `TPSR_CODE_OVF) r = `TPSR_CODE_MAX;
            else if (v == `TPSR_CODE_UNF) r = `TPSR_CODE_MIN;
        end
        return r;
    endfunction : tpsr_encode
endpackage : tpsr_pkg

// ===== hw/tpsr_stream_if.sv
// Purpose: valid/ready byte stream between readout parts
// Assumes: one clock, source holds data while valid and not ready
// Notes: none
`timescale 1ns/100ps
`default_nettype none
interface tpsr_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : tpsr_stream_if
`default_nettype wire

// ===== hw/tpsr_sync2.sv
// Purpose: two-flop level synchroniser
// Assumes: i_d comes from another clock domain
// Notes: first flop is read only by the second
`timescale 1ns/100ps
`default_nettype none
module tpsr_sync2 (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_d,
    output logic      o_q
);
    logic meta;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= 1'b0;
            o_q  <= 1'b0;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule : tpsr_sync2
`default_nettype wire

// ===== hw/tpsr_byte_fifo.sv
// Purpose: small flop fifo in the pixel byte path
// Assumes: single clock
// Notes: no write when full, no read when empty
`timescale 1ns/100ps
`default_nettype none
module tpsr_byte_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic   i_sys_clk,
    input  wire logic   i_rst_n,
    input  wire logic   i_flush,
    tpsr_stream_if.snk  wr,
    tpsr_stream_if.src  rd
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          push;
    logic          pop;
    assign wr.ready = (cnt != (AW+1)'(D)) && !i_flush;
    assign rd.valid = (cnt != '0);
    assign rd.data  = mem[rp];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;
    always_ff @(posedge i_sys_clk) begin
        if (push) mem[wp] <= wr.data;
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else if (i_flush) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            if (push) wp <= (wp == AW'(D - 1)) ? '0 : wp + AW'(1);
            if (pop) rp <= (rp == AW'(D - 1)) ? '0 : rp + AW'(1);
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : tpsr_byte_fifo
`default_nettype wire

// ===== hw/tpsr_readout.sv
// Purpose: spi slave readout of a 64 pixel tof frame
// Assumes: spi mode 0, 16-bit words, msb first
// Notes: answer of a word goes out during the next word
`timescale 1ns/100ps
`default_nettype none
`include "tpsr_defs.svh"
module tpsr_readout
    import tpsr_pkg::*;
#(
    parameter int BOOT_CYCLES = `TPSR_BOOT_TIME_US * `TPSR_CLK_MHZ,
    parameter int FIFO_DEPTH  = `TPSR_FIFO_DEPTH
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_spi_sck,
    input  wire logic        i_spi_cs_n,
    input  wire logic        i_spi_mosi,
    output logic             o_spi_miso,
    output logic             o_spi_miso_oe_n,
    input  wire logic        i_frame_start,
    output logic             o_pair_req,
    output logic [2:0]       o_pair_row,
    output logic [2:0]       o_pair_col,
    input  wire logic        i_pair_ack,
    input  wire logic [11:0] i_pix_even,
    input  wire logic [11:0] i_pix_odd,
    input  wire logic [2:0]  i_flags_even,
    input  wire logic [2:0]  i_flags_odd,
    output logic             o_frame_busy,
    output logic             o_embed_off
);
    localparam int BW = $clog2(BOOT_CYCLES + 1);

    // link side: shift register, bit count, captured word
    logic [3:0]  bit_cnt;
    logic [14:0] rx_shift;
    logic [15:0] rx_word;
    logic        rx_tog;

    // system side
    logic        rx_tog_s;
    logic        rx_tog_d;
    logic        cmd_stb;
    logic        cmd_vld;
    logic        cmd_ok;
    logic [15:0] cmd;
    logic [15:0] tx_word;
    logic [BW-1:0] boot_cnt;
    logic        booted;
    logic        booted_d;
    logic        boot_edge;
    logic [3:0]  page;
    logic [7:0]  rd_mode;
    logic [7:0]  rd_data;
    logic [7:0]  pix_byte;
    logic        is_psel;
    logic        is_write;
    logic        is_read;
    logic        pix_pop;
    logic [5:0]  addr;

    // pair fetch
    tpsr_fetch_e state;
    logic [4:0]  pair_idx;
    logic [23:0] pair_word;
    logic [1:0]  byte_cnt;
    logic        frame_go;
    logic        pair_take;
    logic        byte_push;

    // per-kind column and row indication
    logic [7:0]  col_flags [3];
    logic [7:0]  row_flags [3];

    tpsr_stream_if #(.W(8)) fill ();
    tpsr_stream_if #(.W(8)) drain ();

    // frame resets the link logic, so no edge is needed outside a word
    always_ff @(posedge i_spi_sck or posedge i_spi_cs_n) begin
        if (i_spi_cs_n) begin
            bit_cnt  <= 4'h0;
            rx_shift <= 15'h0000;
        end else begin
            bit_cnt  <= bit_cnt + 4'h1;
            rx_shift <= {rx_shift[13:0], i_spi_mosi};
        end
    end

    always_ff @(posedge i_spi_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_word <= `TPSR_CMD_NOP;
            rx_tog  <= 1'b0;
        end else if (!i_spi_cs_n && bit_cnt == `TPSR_LAST_BIT) begin
            rx_word <= {rx_shift, i_spi_mosi};
            rx_tog  <= ~rx_tog;
        end
    end

    // tx_word changes a few sys clocks after a word ends, and once at boot_edge;
    // the host's gap between words keeps it stable while shifted
    assign o_spi_miso      = tx_word[`TPSR_LAST_BIT - bit_cnt];
    assign o_spi_miso_oe_n = i_spi_cs_n;

    tpsr_sync2 u_sync_word (
        .i_clk   (i_sys_clk),
        .i_rst_n (i_rst_n),
        .i_d     (rx_tog),
        .o_q     (rx_tog_s)
    );

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) rx_tog_d <= 1'b0;
        else rx_tog_d <= rx_tog_s;
    end

    assign cmd_stb = rx_tog_s ^ rx_tog_d;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) cmd <= `TPSR_CMD_NOP;
        else if (cmd_stb) cmd <= rx_word;
    end

    // decode a cycle after capture, from the local copy only,
    // so no logic fans out from the link-domain word
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) cmd_vld <= 1'b0;
        else cmd_vld <= cmd_stb;
    end

    // words that arrive while booting are dropped
    assign cmd_ok   = cmd_vld && booted;

    // command decode of the word just received
    assign addr     = cmd[`TPSR_ADDR_MSB:`TPSR_ADDR_LSB];
    assign is_psel  = cmd[`TPSR_CMD_PSEL_BIT];
    assign is_write = !cmd[`TPSR_CMD_PSEL_BIT] && cmd[`TPSR_CMD_WR_BIT];
    assign is_read  = !cmd[`TPSR_CMD_PSEL_BIT] && !cmd[`TPSR_CMD_WR_BIT]
                      && (cmd != `TPSR_CMD_NOP);
    assign pix_pop  = cmd_ok && is_read && page == `TPSR_PAGE_PIX
                      && addr == `TPSR_REG_PIX_DATA;

    // start-up: busy until the boot count expires
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            boot_cnt <= '0;
            booted   <= 1'b0;
        end else if (!booted) begin
            boot_cnt <= boot_cnt + BW'(1);
            booted   <= (boot_cnt == BW'(BOOT_CYCLES - 1));
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) booted_d <= 1'b0;
        else booted_d <= booted;
    end

    // one-shot: a later all-ones echo must stay an echo
    assign boot_edge = booted && !booted_d;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) page <= 4'h0;
        else if (cmd_ok && is_psel)
            page <= cmd[`TPSR_PAGE_MSB:`TPSR_PAGE_LSB];
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) rd_mode <= `TPSR_MODE_RESET;
        else if (cmd_ok && is_write && page == `TPSR_PAGE_MODE
                 && addr == `TPSR_REG_RD_MODE)
            rd_mode <= cmd[`TPSR_DATA_MSB:0];
    end

    assign o_embed_off = rd_mode[`TPSR_EMBED_OFF_BIT];

    function automatic logic [7:0] reg_read(input logic [3:0] pg, input logic [5:0] a,
                                            input logic [7:0] pix);
        logic [7:0] r;
        r = 8'h00;
        if (pg == `TPSR_PAGE_PIX) begin
            unique case (a)
                `TPSR_REG_PIX_DATA: r = pix;
                `TPSR_REG_SAT_COL:  r = col_flags[`TPSR_FLAG_SAT];
                `TPSR_REG_SAT_ROW:  r = row_flags[`TPSR_FLAG_SAT];
                `TPSR_REG_OVF_COL:  r = col_flags[`TPSR_FLAG_OVF];
                `TPSR_REG_OVF_ROW:  r = row_flags[`TPSR_FLAG_OVF];
                `TPSR_REG_UNF_COL:  r = col_flags[`TPSR_FLAG_UNF];
                `TPSR_REG_UNF_ROW:  r = row_flags[`TPSR_FLAG_UNF];
                default:            r = 8'h00;
            endcase
        end else if (pg == `TPSR_PAGE_MODE && a == `TPSR_REG_RD_MODE) begin
            r = rd_mode;
        end
        return r;
    endfunction : reg_read

    // an empty fifo reads as zero
    assign pix_byte    = drain.valid ? drain.data : 8'h00;
    // always_comb, not assign: reg_read also reads the flag and mode registers
    always_comb begin
        rd_data = reg_read(page, addr, pix_byte);
    end
    assign drain.ready = pix_pop;

    // answer word for the next transfer
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_word <= `TPSR_CMD_BUSY;
        end else if (!booted) begin
            tx_word <= `TPSR_CMD_BUSY;
        end else if (boot_edge && !cmd_vld) begin
            tx_word <= `TPSR_CMD_NOP;
        end else if (cmd_vld) begin
            if (is_read)
                tx_word <= {cmd[`TPSR_CMD_PSEL_BIT:`TPSR_ADDR_LSB], rd_data};
            else
                tx_word <= cmd;
        end
    end

    // pair fetch in centre-out row order
    assign o_pair_req   = (state == FETCH_REQ);
    assign o_pair_row   = tpsr_row_of(pair_idx[4:2]);
    assign o_pair_col   = {pair_idx[1:0], 1'b0};
    assign o_frame_busy = (state != FETCH_IDLE);
    assign fill.valid   = (state == FETCH_PUSH);
    assign fill.data    = pair_word[23:16];
    // stalls in push while the fifo is full; host reads drain it
    assign frame_go     = (state == FETCH_IDLE) && i_frame_start && booted;
    assign pair_take    = (state == FETCH_REQ) && i_pair_ack;
    assign byte_push    = (state == FETCH_PUSH) && fill.ready;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state    <= FETCH_IDLE;
            pair_idx <= 5'h00;
            byte_cnt <= 2'h0;
        end else begin
            unique case (state)
                FETCH_IDLE: begin
                    if (i_frame_start && booted) begin
                        pair_idx <= 5'h00;
                        state    <= FETCH_REQ;
                    end
                end
                FETCH_REQ: begin
                    if (i_pair_ack) begin
                        byte_cnt <= 2'h0;
                        state    <= FETCH_PUSH;
                    end
                end
                FETCH_PUSH: begin
                    if (fill.ready) begin
                        byte_cnt <= byte_cnt + 2'h1;
                        if (byte_cnt == `TPSR_LAST_BYTE) begin
                            // 32 pairs of 3 bytes: 96 reads a frame
                            if (pair_idx == `TPSR_LAST_PAIR) begin
                                state <= FETCH_IDLE;
                            end else begin
                                pair_idx <= pair_idx + 5'h01;
                                state    <= FETCH_REQ;
                            end
                        end
                    end
                end
                default: state <= FETCH_IDLE;
            endcase
        end
    end

    // packed pair: even high, even low with odd low, odd high
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pair_word <= 24'h000000;
        end else if (pair_take) begin
            logic [11:0] ev;
            logic [11:0] od;
            ev = tpsr_encode(i_pix_even, i_flags_even, o_embed_off);
            od = tpsr_encode(i_pix_odd, i_flags_odd, o_embed_off);
            pair_word <= {ev[11:4], ev[3:0], od[3:0], od[11:4]};
        end else if (byte_push) begin
            pair_word <= {pair_word[15:0], 8'h00};
        end
    end

    // indication bits: a new frame clears, a flag in the same cycle still sets
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 3; k++) begin
                col_flags[k] <= 8'h00;
                row_flags[k] <= 8'h00;
            end
        end else begin
            for (int k = 0; k < 3; k++) begin
                logic [7:0] cset;
                logic [7:0] rset;
                cset = 8'h00;
                rset = 8'h00;
                if (pair_take) begin
                    cset[o_pair_col]        = i_flags_even[k];
                    cset[o_pair_col + 3'h1] = i_flags_odd[k];
                    rset[o_pair_row]        = i_flags_even[k] | i_flags_odd[k];
                end
                if (frame_go) begin
                    col_flags[k] <= cset;
                    row_flags[k] <= rset;
                end else begin
                    col_flags[k] <= col_flags[k] | cset;
                    row_flags[k] <= row_flags[k] | rset;
                end
            end
        end
    end

    // a new frame drops stale bytes of an unfinished one
    tpsr_byte_fifo #(
        .W (8),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_flush   (frame_go),
        .wr        (fill.snk),
        .rd        (drain.src)
    );
endmodule : tpsr_readout
`default_nettype wire

// ===== tb/tpsr_readout_checker.sv
// Purpose: port checker of the tof pixel readout
// Assumes: bound to tpsr_readout, frame start only after boot
// Notes: pair_cnt shadows the fetch order
`timescale 1ns/100ps
`default_nettype none
module tpsr_readout_checker (
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic        i_spi_sck,
    input wire logic        i_spi_cs_n,
    input wire logic        i_spi_mosi,
    input wire logic        o_spi_miso,
    input wire logic        o_spi_miso_oe_n,
    input wire logic        i_frame_start,
    input wire logic        o_pair_req,
    input wire logic [2:0]  o_pair_row,
    input wire logic [2:0]  o_pair_col,
    input wire logic        i_pair_ack,
    input wire logic [11:0] i_pix_even,
    input wire logic [11:0] i_pix_odd,
    input wire logic [2:0]  i_flags_even,
    input wire logic [2:0]  i_flags_odd,
    input wire logic        o_frame_busy,
    input wire logic        o_embed_off
);
    localparam logic [2:0] ROWS [8] = '{3'h3, 3'h4, 3'h2, 3'h5, 3'h1, 3'h6, 3'h0, 3'h7};
    logic [4:0] pair_cnt;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // wraps to zero after 32 pairs
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pair_cnt <= 5'h00;
        end else if (i_frame_start && !o_frame_busy) begin
            pair_cnt <= 5'h00;
        end else if (i_pair_ack && o_pair_req) begin
            pair_cnt <= pair_cnt + 5'h01;
        end
    end
    sequence s_accept;
        i_frame_start && !o_frame_busy;
    endsequence
    sequence s_first;
        o_pair_req && o_frame_busy && o_pair_row == 3'h3 && o_pair_col == 3'h0;
    endsequence
    frame_begin_a: assert property (s_accept |=> s_first)
        else $error("frame start did not ask row 3 col 0");
    pair_order_a: assert property (o_pair_req |-> o_pair_row == ROWS[pair_cnt[4:2]]
                                   && o_pair_col == {pair_cnt[1:0], 1'b0})
        else $error("pair requested out of order");
    pair_hold_a: assert property (o_pair_req && !i_pair_ack |=> o_pair_req
                                  && $stable(o_pair_row) && $stable(o_pair_col))
        else $error("pair request moved before ack");
    ack_drop_a: assert property (o_pair_req && i_pair_ack |=> !o_pair_req)
        else $error("request stayed after ack");
    frame_len_a: assert property ($fell(o_frame_busy) |-> pair_cnt == 5'h00)
        else $error("frame ended short of 32 pairs");
    busy_cause_a: assert property ($rose(o_frame_busy) |-> $past(i_frame_start))
        else $error("busy rose without frame start");
    req_busy_a: assert property (o_pair_req |-> o_frame_busy)
        else $error("request outside a frame");
    oe_follow_a: assert property (o_spi_miso_oe_n == i_spi_cs_n)
        else $error("miso enable does not follow select");
endmodule : tpsr_readout_checker
bind tpsr_readout tpsr_readout_checker chk (.i_sys_clk, .i_rst_n, .i_spi_sck, .i_spi_cs_n, .i_spi_mosi,
    .o_spi_miso, .o_spi_miso_oe_n, .i_frame_start, .o_pair_req, .o_pair_row, .o_pair_col, .i_pair_ack,
    .i_pix_even, .i_pix_odd, .i_flags_even, .i_flags_odd, .o_frame_busy, .o_embed_off);
`default_nettype wire

// ===== tb/tpsr_host_model.sv
// Purpose: spi master standing in for the host
// Assumes: mode 0, 16-bit words, 12 ns sck
// Notes: gap_ns sets how slowly words follow
`timescale 1ns/100ps
`default_nettype none
module tpsr_host_model (
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi,
    input  wire logic i_miso,
    input  wire logic i_miso_oe_n
);
    int gap_ns = 400;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // sck rests low outside words
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] ans);
        o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_mosi = cmd[i];
            #6;
            ans[i] = i_miso_oe_n ? 1'bx : i_miso;
            o_sck = 1'b1;
            #6;
            o_sck = 1'b0;
        end
        #6;
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        // device needs 4 sys clocks to take the word and update its answer
        #(gap_ns);
    endtask : xfer
endmodule : tpsr_host_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the tof pixel readout
// Assumes: boot shortened to 16 cycles
// Notes: row 3 carries the marker cases
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [2:0] ROW_ORDER [8] = '{3'h3, 3'h4, 3'h2, 3'h5, 3'h1, 3'h6, 3'h0, 3'h7};
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        frame_start = 1'b0;
    logic        pair_ack = 1'b0;
    logic [11:0] pix_even = 12'h000;
    logic [11:0] pix_odd = 12'h000;
    logic [2:0]  flags_even = 3'h0;
    logic [2:0]  flags_odd = 3'h0;
    logic [15:0] exp_ans = 16'hffff;
    wire logic   sck, cs_n, mosi, miso, miso_oe_n, pair_req, frame_busy, embed_off;
    wire logic [2:0] pair_row, pair_col;
    int          n_mismatch = 0;
    int          compares = 0;

    always #20 sys_clk = ~sys_clk;

    tpsr_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso), .i_miso_oe_n(miso_oe_n));
    tpsr_readout #(.BOOT_CYCLES(16)) dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_spi_sck(sck),
        .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe_n(miso_oe_n),
        .i_frame_start(frame_start), .o_pair_req(pair_req), .o_pair_row(pair_row), .o_pair_col(pair_col),
        .i_pair_ack(pair_ack), .i_pix_even(pix_even), .i_pix_odd(pix_odd), .i_flags_even(flags_even),
        .i_flags_odd(flags_odd), .o_frame_busy(frame_busy), .o_embed_off(embed_off));

    function automatic logic [14:0] src(input logic [2:0] r, input logic [2:0] c, input logic o);
        if (r != 3'h3) return {3'h0, 1'b0, r, c, o, 4'ha};
        case ({c[2:1], o})
            3'h0: return {3'h1, 12'h123};
            3'h1: return {3'h2, 12'h456};
            3'h2: return {3'h4, 12'h789};
            3'h3: return {3'h0, 12'h7ff};
            3'h4: return {3'h0, 12'h800};
            3'h5: return {3'h0, 12'h7fe};
            default: return {3'h0, 12'h7fd};
        endcase
    endfunction : src

    function automatic logic [11:0] cook(input logic [14:0] s, input logic off);
        if (off) return s[11:0];
        if (s[12]) return 12'h7ff;
        if (s[13]) return 12'h7fe;
        if (s[14]) return 12'h800;
        if (s[11:0] == 12'h7ff || s[11:0] == 12'h7fe) return 12'h7fd;
        if (s[11:0] == 12'h800) return 12'h801;
        return s[11:0];
    endfunction : cook

    // pixel source answers one cycle after each request
    always @(negedge sys_clk) begin
        pair_ack <= pair_req && !pair_ack;
        {flags_even, pix_even} <= src(pair_row, pair_col, 1'b0);
        {flags_odd, pix_odd} <= src(pair_row, pair_col, 1'b1);
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // answer of a word arrives during the next one
    task automatic xchk(input logic [15:0] cmd, input logic [15:0] nxt);
        logic [15:0] a;
        host.xfer(cmd, a);
        check(a, exp_ans);
        exp_ans = nxt;
    endtask : xchk

    task automatic t_boot;
        logic [15:0] a;
        int n;
        host.xfer(16'h0000, a);
        check(a, 16'hffff);
        n = 0;
        while (a !== 16'h0000 && n < 20) begin
            host.xfer(16'h0000, a);
            n++;
        end
        check(a, 16'h0000);
        exp_ans = 16'h0000;
    endtask : t_boot

    // sequencer load lives outside this block
    task automatic t_adjust;
        logic [15:0] cmds [4] = '{16'h8100, 16'h5a00, 16'h8500, 16'h4b00};
        foreach (cmds[i]) xchk(cmds[i], cmds[i]);
    endtask : t_adjust

    task automatic t_frame(input logic off);
        logic [11:0] pe, po;
        logic [2:0] r, c;
        logic [7:0] b [3];
        check({15'h0, embed_off}, {15'h0, off});
        @(negedge sys_clk) frame_start <= 1'b1;
        @(negedge sys_clk) frame_start <= 1'b0;
        // fifo fills and the source stalls meanwhile
        repeat (30) @(negedge sys_clk);
        xchk(16'h8200, 16'h8200);
        for (int k = 0; k < 32; k++) begin
            r = ROW_ORDER[k[4:2]];
            c = {k[1:0], 1'b0};
            pe = cook(src(r, c, 1'b0), off);
            po = cook(src(r, c, 1'b1), off);
            b = '{pe[11:4], {pe[3:0], po[3:0]}, po[11:4]};
            for (int j = 0; j < 3; j++) xchk(16'h0c00, {8'h0c, b[j]});
        end
        xchk(16'h0c00, 16'h0c00);
        xchk(16'h0000, 16'h0000);
        check({15'h0, frame_busy}, 16'h0000);
    endtask : t_frame

    task automatic t_flags;
        logic [7:0] want [7] = '{8'h01, 8'h08, 8'h02, 8'h08, 8'h04, 8'h08, 8'h00};
        logic [5:0] addr [7] = '{6'h0d, 6'h0e, 6'h10, 6'h11, 6'h12, 6'h13, 6'h3f};
        foreach (addr[i]) xchk({2'b00, addr[i], 8'h00}, {2'b00, addr[i], want[i]});
        xchk(16'h0000, 16'h0000);
    endtask : t_flags

    task automatic t_mode;
        xchk(16'h8400, 16'h8400);
        xchk(16'h5540, 16'h5540);
        xchk(16'h1500, 16'h1540);
        xchk(16'h0000, 16'h0000);
        check({15'h0, embed_off}, 16'h0001);
    endtask : t_mode

    initial begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_boot;
        t_adjust;
        t_frame(1'b0);
        t_flags;
        t_mode;
        host.gap_ns = 1500;
        t_frame(1'b1);
        stop_test;
    end

    // whole run needs well under half of this
    initial begin
        #1_000_000;
        n_mismatch++;
        stop_test;
    end
endmodule : tb_top
`default_nettype wire
